// ---- core/sspg_pkg.sv ----
// Purpose: Shared constants, types and state layout of the start-up sequencer
// Assumes: 50 MHz core clock; times counted in whole milliseconds
// Notes: Pin straps arrive as two-bit level codes plus a resistor index
package sspg_pkg;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int MS_PER_S = 1000;
    localparam int TICK_CYCLES_DEF = CLK_HZ / MS_PER_S;
    localparam int PRE_W = 16;
    localparam int NVM_CHECK_MS = 5;
    localparam int MIN_DELAY_MS = 2;
    localparam int MS_W = 8;
    localparam int VREF_W = 12;
    // ----------------------------------------------------------------
    // Strap decoding
    // ----------------------------------------------------------------
    localparam logic [1:0] LVL_LOW = 2'h0;
    localparam logic [1:0] LVL_OPEN = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;
    localparam logic [1:0] LVL_RES = 2'h3;
    localparam int RES_IDX_W = 5;
    localparam logic [4:0] RES_IDX_MAX = 5'h14;
    localparam logic [7:0] RES_STEP_MS = 8'h0a;
    localparam logic [7:0] RAMP_OPEN_MS = 8'h05;
    localparam logic [7:0] RAMP_HIGH_MS = 8'h0a;
    localparam logic [7:0] DLY_LO_LOW = 8'h00;
    localparam logic [7:0] DLY_LO_OPEN = 8'h01;
    localparam logic [7:0] DLY_LO_HIGH = 8'h02;
    localparam logic [7:0] DLY_MID_LOW = 8'h05;
    localparam logic [7:0] DLY_MID_OPEN = 8'h0a;
    localparam logic [7:0] DLY_MID_HIGH = 8'h14;
    localparam logic [7:0] DLY_HI_LOW = 8'h32;
    localparam logic [7:0] DLY_HI_OPEN = 8'h64;
    localparam logic [7:0] DLY_HI_HIGH = 8'hc8;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DELAY = 8'h04;
    localparam logic [7:0] OFS_RAMP = 8'h08;
    localparam logic [7:0] OFS_GOOD_DLY = 8'h0c;
    localparam logic [7:0] OFS_TARGET = 8'h10;
    localparam logic [7:0] OFS_LIMITS = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam int CTRL_RESTORE_BIT = 0;
    localparam int CTRL_PRECISE_BIT = 1;
    localparam int CTRL_GOOD_INV_BIT = 2;
    localparam int LIM_OV_LSB = 8;
    localparam int ST_READY_BIT = 4;
    localparam int ST_GOOD_BIT = 5;
    localparam int ST_VREF_LSB = 16;
    localparam logic [7:0] RST_UV_PCT = 8'h0a;
    localparam logic [7:0] RST_OV_PCT = 8'h0f;
    localparam logic [7:0] PCT_FULL = 8'h64;

    typedef enum logic [2:0] {
        SEQ_NVM,
        SEQ_PINS,
        SEQ_READY,
        SEQ_DELAY,
        SEQ_RAMP,
        SEQ_ON
    } sspg_state_type;

    typedef struct packed {
        logic [1:0] en;
        logic [1:0] fault;
        logic [1:0][1:0] lvl_lo;
        logic [1:0][1:0] lvl_hi;
        logic [1:0][1:0] lvl_ramp;
        logic [1:0][RES_IDX_W-1:0] res_lo;
        logic [1:0][RES_IDX_W-1:0] res_ramp;
        logic [1:0][VREF_W-1:0] sense;
        sspg_state_type state;
        logic [PRE_W-1:0] pre;
        logic [MS_W-1:0] msc;
        logic [MS_W-1:0] good_cnt;
        logic precise;
        logic good_inv;
        logic good_dly_set;
        logic [MS_W-1:0] delay_ms;
        logic [MS_W-1:0] ramp_ms;
        logic [MS_W-1:0] good_dly_ms;
        logic [VREF_W-1:0] target;
        logic [7:0] uv_pct;
        logic [7:0] ov_pct;
        logic [VREF_W-1:0] vref;
        logic good_act;
        logic good_pin;
        logic ready;
        logic ack;
        logic [31:0] dat;
    } sspg_st_type;
endpackage

// ---- core/sspg_seq.sv ----
// Purpose: Power-up sequencer with delay, monotonic ramp and output-good
// Assumes: Wishbone classic slave, synchronous active-high reset at supply up
// Notes: Straps and sensed levels are asynchronous and pass two flip-flops
//
// How it works
// - After reset, wait then load stored settings
// - Then sample straps and load their settings only if no valid stored settings were loaded
// - Ignore enable and bus writes while initialising
// - Restore command reruns the stored-settings check
// - Accept commands and enable only once ready
// - Pre-ramp delay never shorter than 2 ms
// - Longer configured delay is honoured in full, except 255 ms without precise timing
// - Delay counts from enable assertion
// - Delay decoded from two three-level select pins
// - Ramp reference rises monotonically to target
// - Ramp time from ramp pin: 0/5/10 ms
// - Zero ramp jumps straight to target
// - Resistor index selects 0-200 ms in 10 ms
// - Resistor read only at start-up or restore
// - Bus writes override strap delay and ramp
// - Precise delay timing only when control bit set
// - Good only in window, no fault; default -10/+15%
// - Window limits and good polarity bus-writable
// - Good asserts after delay; default equals ramp
// - Good delay writable independently of ramp
//
// Chosen here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
module sspg_seq #(
    parameter int TICK_CYCLES = sspg_pkg::TICK_CYCLES_DEF,
    parameter logic [11:0] TARGET_DEF = 12'h800
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic enable_i,
    input wire logic fault_i,
    input wire logic [1:0] delay_select_low_pin_i,
    input wire logic [1:0] delay_select_high_pin_i,
    input wire logic [1:0] ramp_select_pin_i,
    input wire logic [4:0] delay_res_idx_i,
    input wire logic [4:0] ramp_res_idx_i,
    input wire logic nvm_valid_i,
    input wire logic [7:0] nvm_delay_ms_i,
    input wire logic [7:0] nvm_ramp_ms_i,
    input wire logic [11:0] vout_sense_i,
    output logic [11:0] vout_ref_o,
    output logic output_good_o,
    output logic ready_o
);
    initial begin
        if (TICK_CYCLES < 2 || TICK_CYCLES >= (1 << sspg_pkg::PRE_W)) begin
            $error("TICK_CYCLES out of range");
        end
    end

    sspg_pkg::sspg_st_type st_r, st_nxt;
    localparam int PRE_W = sspg_pkg::PRE_W;
    localparam int VREF_W = sspg_pkg::VREF_W;

    // ----------------------------------------------------------------
    // Decoders
    // ----------------------------------------------------------------
    function automatic logic [7:0] res_ms(input logic [4:0] idx);
        logic [4:0] c;
        c = (idx > sspg_pkg::RES_IDX_MAX) ? sspg_pkg::RES_IDX_MAX : idx;
        return 8'({3'h0, c} * sspg_pkg::RES_STEP_MS);
    endfunction

    function automatic logic [7:0] pick3(input logic [1:0] l, input logic [7:0] a,
                                         input logic [7:0] b, input logic [7:0] c);
        case (l)
            sspg_pkg::LVL_LOW: return a;
            sspg_pkg::LVL_HIGH: return c;
            default: return b;
        endcase
    endfunction

    function automatic logic [7:0] wmask(input logic [7:0] old, input logic [7:0] nw,
                                         input logic en);
        return en ? nw : old;
    endfunction

    logic [7:0] pin_delay, pin_ramp, eff_delay, wait_ms, vmul_ms;
    logic [19:0] lim_lo, lim_hi, ramp_prod;
    logic in_window, tick, req, wr, good_cond;

    always_comb begin
        // Straps decoded every cycle but loaded only in SEQ_PINS, so later resistor changes are inert
        if (st_r.lvl_lo[1] == sspg_pkg::LVL_RES) begin
            pin_delay = res_ms(st_r.res_lo[1]);
        end else begin
            case (st_r.lvl_hi[1])
                sspg_pkg::LVL_LOW: pin_delay = pick3(st_r.lvl_lo[1], sspg_pkg::DLY_LO_LOW,
                    sspg_pkg::DLY_LO_OPEN, sspg_pkg::DLY_LO_HIGH);
                sspg_pkg::LVL_HIGH: pin_delay = pick3(st_r.lvl_lo[1], sspg_pkg::DLY_HI_LOW,
                    sspg_pkg::DLY_HI_OPEN, sspg_pkg::DLY_HI_HIGH);
                default: pin_delay = pick3(st_r.lvl_lo[1], sspg_pkg::DLY_MID_LOW,
                    sspg_pkg::DLY_MID_OPEN, sspg_pkg::DLY_MID_HIGH);
            endcase
        end
        if (st_r.lvl_ramp[1] == sspg_pkg::LVL_RES) begin
            pin_ramp = res_ms(st_r.res_ramp[1]);
        end else begin
            pin_ramp = pick3(st_r.lvl_ramp[1], 8'h00, sspg_pkg::RAMP_OPEN_MS,
                sspg_pkg::RAMP_HIGH_MS);
        end
        eff_delay = (st_r.delay_ms < 8'(sspg_pkg::MIN_DELAY_MS)) ?
            8'(sspg_pkg::MIN_DELAY_MS) : st_r.delay_ms;
        // Free-running tick may land early, so one more tick keeps the minimum
        wait_ms = (st_r.precise || eff_delay == '1) ? eff_delay : 8'(eff_delay + 8'h01);
        lim_lo = 20'({8'h00, st_r.target} * {12'h000, 8'(sspg_pkg::PCT_FULL - st_r.uv_pct)});
        lim_hi = 20'({8'h00, st_r.target} * {12'h000, 8'(sspg_pkg::PCT_FULL + st_r.ov_pct)});
        in_window = (20'({8'h00, st_r.sense[1]} * {12'h000, sspg_pkg::PCT_FULL}) >= lim_lo)
            && (20'({8'h00, st_r.sense[1]} * {12'h000, sspg_pkg::PCT_FULL}) <= lim_hi);
        good_cond = in_window && !st_r.fault[1] && st_r.state == sspg_pkg::SEQ_ON;
        vmul_ms = st_r.msc;
        ramp_prod = 20'({8'h00, st_r.target} * {12'h000, vmul_ms});
        tick = (st_r.pre == PRE_W'(TICK_CYCLES - 1));
        req = wb_cyc_i && wb_stb_i && !st_r.ack;
        wr = req && wb_we_i && st_r.ready;
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.en = {st_r.en[0], enable_i};
        st_nxt.fault = {st_r.fault[0], fault_i};
        st_nxt.lvl_lo = {st_r.lvl_lo[0], delay_select_low_pin_i};
        st_nxt.lvl_hi = {st_r.lvl_hi[0], delay_select_high_pin_i};
        st_nxt.lvl_ramp = {st_r.lvl_ramp[0], ramp_select_pin_i};
        st_nxt.res_lo = {st_r.res_lo[0], delay_res_idx_i};
        st_nxt.res_ramp = {st_r.res_ramp[0], ramp_res_idx_i};
        st_nxt.sense = {st_r.sense[0], vout_sense_i};
        st_nxt.pre = tick ? '0 : PRE_W'(st_r.pre + 1'b1);
        if (tick && st_r.msc != '1) begin
            st_nxt.msc = st_r.msc + 8'h01;
        end
        st_nxt.ack = req;
        st_nxt.dat = '0;
        // Bus: reads always answer; writes ignored until ready
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                sspg_pkg::OFS_CTRL: st_nxt.dat = 32'({st_r.good_inv, st_r.precise, 1'b0});
                sspg_pkg::OFS_DELAY: st_nxt.dat = 32'(st_r.delay_ms);
                sspg_pkg::OFS_RAMP: st_nxt.dat = 32'(st_r.ramp_ms);
                sspg_pkg::OFS_GOOD_DLY: st_nxt.dat = 32'(st_r.good_dly_ms);
                sspg_pkg::OFS_TARGET: st_nxt.dat = 32'(st_r.target);
                sspg_pkg::OFS_LIMITS: st_nxt.dat = 32'({st_r.ov_pct, st_r.uv_pct});
                sspg_pkg::OFS_STATUS: begin
                    st_nxt.dat[2:0] = st_r.state;
                    st_nxt.dat[sspg_pkg::ST_READY_BIT] = st_r.ready;
                    st_nxt.dat[sspg_pkg::ST_GOOD_BIT] = st_r.good_act;
                    st_nxt.dat[sspg_pkg::ST_VREF_LSB +: VREF_W] = st_r.vref;
                end
                default: st_nxt.dat = '0;
            endcase
        end
        if (wr) begin
            case (wb_adr_i)
                sspg_pkg::OFS_CTRL: begin
                    if (wb_sel_i[0]) begin
                        st_nxt.precise = wb_dat_i[sspg_pkg::CTRL_PRECISE_BIT];
                        st_nxt.good_inv = wb_dat_i[sspg_pkg::CTRL_GOOD_INV_BIT];
                    end
                end
                sspg_pkg::OFS_DELAY: st_nxt.delay_ms =
                    wmask(st_r.delay_ms, wb_dat_i[7:0], wb_sel_i[0]);
                sspg_pkg::OFS_RAMP: st_nxt.ramp_ms =
                    wmask(st_r.ramp_ms, wb_dat_i[7:0], wb_sel_i[0]);
                sspg_pkg::OFS_GOOD_DLY: begin
                    st_nxt.good_dly_ms = wmask(st_r.good_dly_ms, wb_dat_i[7:0], wb_sel_i[0]);
                    st_nxt.good_dly_set = st_r.good_dly_set | wb_sel_i[0];
                end
                sspg_pkg::OFS_TARGET: begin
                    st_nxt.target[7:0] = wmask(st_r.target[7:0], wb_dat_i[7:0], wb_sel_i[0]);
                    if (wb_sel_i[1]) begin
                        st_nxt.target[11:8] = wb_dat_i[11:8];
                    end
                end
                sspg_pkg::OFS_LIMITS: begin
                    st_nxt.uv_pct = wmask(st_r.uv_pct, wb_dat_i[7:0], wb_sel_i[0]);
                    st_nxt.ov_pct = wmask(st_r.ov_pct,
                        wb_dat_i[sspg_pkg::LIM_OV_LSB +: 8], wb_sel_i[1]);
                end
                default: ;
            endcase
        end
        if (!st_nxt.good_dly_set) begin
            st_nxt.good_dly_ms = st_nxt.ramp_ms;
        end
        // ----------------------------------------------------------------
        // Sequencer
        // ----------------------------------------------------------------
        case (st_r.state)
            sspg_pkg::SEQ_NVM: begin
                st_nxt.ready = 1'b0;
                st_nxt.vref = '0;
                if (st_r.msc >= 8'(sspg_pkg::NVM_CHECK_MS)) begin
                    if (nvm_valid_i) begin
                        st_nxt.delay_ms = nvm_delay_ms_i;
                        st_nxt.ramp_ms = nvm_ramp_ms_i;
                    end
                    st_nxt.state = sspg_pkg::SEQ_PINS;
                end
            end
            sspg_pkg::SEQ_PINS: begin
                // Stored values take priority over straps
                if (!nvm_valid_i) begin
                    st_nxt.delay_ms = pin_delay;
                    st_nxt.ramp_ms = pin_ramp;
                end
                if (!st_r.good_dly_set) begin
                    st_nxt.good_dly_ms = nvm_valid_i ? st_r.ramp_ms : pin_ramp;
                end
                st_nxt.ready = 1'b1;
                st_nxt.state = sspg_pkg::SEQ_READY;
            end
            sspg_pkg::SEQ_READY: begin
                st_nxt.vref = '0;
                if (st_r.en[1]) begin
                    st_nxt.msc = '0;
                    if (st_r.precise) begin
                        st_nxt.pre = '0;
                    end
                    st_nxt.state = sspg_pkg::SEQ_DELAY;
                end
            end
            sspg_pkg::SEQ_DELAY: begin
                if (st_r.msc >= wait_ms) begin
                    st_nxt.msc = '0;
                    st_nxt.pre = '0;
                    st_nxt.state = sspg_pkg::SEQ_RAMP;
                end
            end
            sspg_pkg::SEQ_RAMP: begin
                if (st_r.ramp_ms == '0 || st_r.msc >= st_r.ramp_ms) begin
                    st_nxt.vref = st_r.target;
                    st_nxt.msc = '0;
                    st_nxt.state = sspg_pkg::SEQ_ON;
                end else begin
                    // Quotient only grows while neither target nor ramp time is rewritten over the bus during the ramp
                    st_nxt.vref = VREF_W'(ramp_prod / {12'h000, st_r.ramp_ms});
                end
            end
            sspg_pkg::SEQ_ON: st_nxt.vref = st_r.target;
            default: st_nxt.state = sspg_pkg::SEQ_NVM;
        endcase
        if (!st_r.en[1] && st_r.state inside {sspg_pkg::SEQ_DELAY, sspg_pkg::SEQ_RAMP,
                                              sspg_pkg::SEQ_ON}) begin
            st_nxt.state = sspg_pkg::SEQ_READY;
            st_nxt.vref = '0;
        end
        if (wr && wb_adr_i == sspg_pkg::OFS_CTRL && wb_sel_i[0]
            && wb_dat_i[sspg_pkg::CTRL_RESTORE_BIT]) begin
            st_nxt.state = sspg_pkg::SEQ_NVM;
            st_nxt.msc = '0;
            st_nxt.vref = '0;
            st_nxt.ready = 1'b0;
        end
        // ----------------------------------------------------------------
        // Output good
        // ----------------------------------------------------------------
        if (!good_cond) begin
            st_nxt.good_act = 1'b0;
            st_nxt.good_cnt = '0;
        end else if (!st_r.good_act) begin
            if (st_r.good_cnt >= st_r.good_dly_ms) begin
                st_nxt.good_act = 1'b1;
            end else if (tick) begin
                st_nxt.good_cnt = st_r.good_cnt + 8'h01;
            end
        end
        st_nxt.good_pin = st_nxt.good_act ^ st_nxt.good_inv;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
            st_r.state <= sspg_pkg::SEQ_NVM;
            st_r.target <= TARGET_DEF;
            st_r.uv_pct <= sspg_pkg::RST_UV_PCT;
            st_r.ov_pct <= sspg_pkg::RST_OV_PCT;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wb_ack_o = st_r.ack;
    assign wb_dat_o = st_r.dat;
    assign vout_ref_o = st_r.vref;
    assign output_good_o = st_r.good_pin;
    assign ready_o = st_r.ready;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_enable_seen;
        st_r.state == sspg_pkg::SEQ_READY && st_r.en[1];
    endsequence
    property p_enable_starts;
        @(posedge clk_i) disable iff (rst_i)
        s_enable_seen ##1 1'b1 |-> st_r.state == sspg_pkg::SEQ_DELAY
            || st_r.state == sspg_pkg::SEQ_NVM;
    endproperty
    a_enable_starts: assert property (p_enable_starts) else $error("enable missed");
    property p_min_delay;
        @(posedge clk_i) disable iff (rst_i)
        $past(st_r.state) == sspg_pkg::SEQ_DELAY && st_r.state == sspg_pkg::SEQ_RAMP
            |-> $past(st_r.msc) >= 8'(sspg_pkg::MIN_DELAY_MS);
    endproperty
    a_min_delay: assert property (p_min_delay) else $error("delay short");
    property p_init_ignores;
        @(posedge clk_i) disable iff (rst_i)
        (st_r.state == sspg_pkg::SEQ_NVM) |-> !st_r.ready ##1 st_r.state != sspg_pkg::SEQ_DELAY;
    endproperty
    a_init_ignores: assert property (p_init_ignores) else $error("busy not ignored");
    property p_monotonic;
        @(posedge clk_i) disable iff (rst_i)
        st_r.state == sspg_pkg::SEQ_RAMP ##1 st_r.state inside {sspg_pkg::SEQ_RAMP,
            sspg_pkg::SEQ_ON} |-> st_r.vref >= $past(st_r.vref);
    endproperty
    a_monotonic: assert property (p_monotonic) else $error("ramp reversed");
    property p_good_drop;
        @(posedge clk_i) disable iff (rst_i)
        !good_cond |=> !st_r.good_act;
    endproperty
    a_good_drop: assert property (p_good_drop) else $error("good held");
    property p_good_pol;
        @(posedge clk_i) disable iff (rst_i)
        st_r.good_pin == (st_r.good_act ^ st_r.good_inv);
    endproperty
    a_good_pol: assert property (p_good_pol) else $error("good polarity");
    property p_abort;
        @(posedge clk_i) disable iff (rst_i)
        !st_r.en[1] && st_r.state == sspg_pkg::SEQ_RAMP |=> st_r.vref == '0;
    endproperty
    a_abort: assert property (p_abort) else $error("no abort");
    property p_ack;
        @(posedge clk_i) disable iff (rst_i)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack timing");
    property p_ready_late;
        @(posedge clk_i) disable iff (rst_i)
        st_r.ready |-> !(st_r.state inside {sspg_pkg::SEQ_NVM, sspg_pkg::SEQ_PINS});
    endproperty
    a_ready_late: assert property (p_ready_late) else $error("ready too early");
    property p_restore;
        @(posedge clk_i) disable iff (rst_i)
        wr && wb_adr_i == sspg_pkg::OFS_CTRL && wb_sel_i[0]
            && wb_dat_i[sspg_pkg::CTRL_RESTORE_BIT] |=> st_r.state == sspg_pkg::SEQ_NVM;
    endproperty
    a_restore: assert property (p_restore) else $error("restore missed");
    property p_zero_ramp;
        @(posedge clk_i) disable iff (rst_i)
        st_r.state == sspg_pkg::SEQ_RAMP && st_r.ramp_ms == '0 && st_r.en[1] && !wr
            |=> st_r.vref == st_r.target;
    endproperty
    a_zero_ramp: assert property (p_zero_ramp) else $error("zero ramp slow");
    sequence s_good_rises;
        !st_r.good_act ##1 st_r.good_act;
    endsequence
    property p_good_wait;
        @(posedge clk_i) disable iff (rst_i)
        s_good_rises |-> $past(st_r.good_cnt) >= $past(st_r.good_dly_ms);
    endproperty
    a_good_wait: assert property (p_good_wait) else $error("good too soon");
endmodule // sspg_seq

// ---- verif/sspg_load_model.sv ----
// Purpose: Power stage and load seen by the sequencer
// Assumes: Sensed output follows the reference one cycle later
// Notes: Sag halves the output, trip raises the fault line
`timescale 1ns/1ps
module sspg_load_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [11:0] vref_i,
    input wire logic sag_i,
    input wire logic trip_i,
    output logic [11:0] sense_o,
    output logic fault_o
);
    // Registered so a window exit reaches the sequencer like a real filter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sense_o <= 12'h000;
            fault_o <= 1'b0;
        end else begin
            sense_o <= sag_i ? {1'b0, vref_i[11:1]} : vref_i;
            fault_o <= trip_i;
        end
    end
endmodule // sspg_load_model

// ---- verif/startup_softstart_powergood_seq_tb.sv ----
// Purpose: Self-checking bench for the start-up sequencer
// Assumes: Short millisecond tick so a full sequence stays brief
// Notes: Stored settings appear only in the last step; straps and bus supply the rest
`timescale 1ns/1ps
module startup_softstart_powergood_seq_tb;
    localparam int T = 20;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, en = 1'b0, sag = 1'b0, trip = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, q, rd_dat;
    logic [1:0] d_lo = 2'h1, d_hi = 2'h0, r_pin = 2'h1;
    logic [4:0] d_idx = 5'h00, r_idx = 5'h00;
    logic [11:0] sense, vref_o;
    logic fault, ack, output_good_o, ready_o;
    logic nvm_v = 1'b0;
    logic [7:0] dtab [9] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h0a, 8'h14, 8'h32, 8'h64, 8'hc8};
    int fail_count = 0, total_checks = 0, n;
    always #10 clk_i = ~clk_i;
    sspg_seq #(.TICK_CYCLES(T)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(rd_dat), .wb_ack_o(ack), .enable_i(en), .fault_i(fault),
        .delay_select_low_pin_i(d_lo), .delay_select_high_pin_i(d_hi),
        .ramp_select_pin_i(r_pin), .delay_res_idx_i(d_idx), .ramp_res_idx_i(r_idx),
        .nvm_valid_i(nvm_v), .nvm_delay_ms_i(8'h07), .nvm_ramp_ms_i(8'h00),
        .vout_sense_i(sense), .vout_ref_o(vref_o), .output_good_o(output_good_o),
        .ready_o(ready_o));
    sspg_load_model LOAD (.clk_i(clk_i), .rst_i(rst_i), .vref_i(vref_o), .sag_i(sag),
        .trip_i(trip), .sense_o(sense), .fault_o(fault));
    // ----------------------------------------------------------------
    // Checking and bus tasks
    // ----------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic bad(input string m);
        fail_count++;
        $display("unexpected at %0t: %s", $time, m);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) bad(m);
    endtask
    task automatic chk_rng(input int v, input int lo, input int hi, input string m);
        total_checks++;
        if (v < lo || v > hi) bad(m);
    endtask
    // Classic cycle: hold until ack is sampled, then release for a cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int k;
        k = 0;
        cyc <= 1'b1; we <= w; adr <= a; wdat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1) begin
            if (++k > 50) begin bad("no ack"); report_and_stop(); end
            @(posedge clk_i);
        end
        r = rd_dat;
        cyc <= 1'b0; we <= 1'b0;
        @(posedge clk_i);
    endtask
    // Kinds: 0 ready, 1 reference moved, 2 reference at target, 3 good, 4 good gone
    task automatic wait_for(input int which, input int lim, output int c);
        logic hit;
        logic [11:0] prev;
        c = 0; hit = 1'b0; prev = vref_o;
        while (!hit) begin
            @(posedge clk_i);
            c++;
            if (which == 2 && vref_o < prev) bad("ramp reversed");
            prev = vref_o;
            case (which)
                0: hit = (ready_o === 1'b1);
                1: hit = (vref_o !== 12'h000);
                2: hit = (vref_o === 12'h800);
                3: hit = (output_good_o === 1'b1);
                default: hit = (output_good_o === 1'b0);
            endcase
            if (!hit && c >= lim) begin bad("wait ran out"); report_and_stop(); end
        end
    endtask
    task automatic restore();
        wb(1'b1, sspg_pkg::OFS_CTRL, 32'h1, q);
        chk(ready_o, 1'b0, "ready kept on restore");
        wait_for(0, 8 * T, n);
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b1, sspg_pkg::OFS_DELAY, 32'h9, q);
        chk(ready_o, 1'b0, "ready too early");
        wait_for(0, 8 * T, n);
        chk_rng(n + 3, 5 * T - 8, 5 * T + 8, "check length");
        wb(1'b0, sspg_pkg::OFS_DELAY, 32'h0, q);
        chk(q, 32'h1, "write taken while busy");
        wb(1'b0, sspg_pkg::OFS_LIMITS, 32'h0, q);
        chk(q, 32'h0f0a, "window default");
        wb(1'b0, 8'hfc, 32'h0, q);
        chk(q, 32'h0, "unmapped read");
        for (int i = 0; i < 9; i++) begin
            d_hi <= 2'(i / 3);
            d_lo <= 2'(i % 3);
            r_pin <= 2'(i % 3);
            restore();
            wb(1'b0, sspg_pkg::OFS_DELAY, 32'h0, q);
            chk(q, {24'h0, dtab[i]}, "strap delay");
            wb(1'b0, sspg_pkg::OFS_RAMP, 32'h0, q);
            chk(q, 32'(5 * (i % 3)), "strap ramp");
        end
        d_lo <= 2'h3; d_idx <= 5'h07; r_pin <= 2'h3; r_idx <= 5'h14;
        restore();
        wb(1'b0, sspg_pkg::OFS_DELAY, 32'h0, q);
        chk(q, 32'h46, "resistor delay");
        wb(1'b0, sspg_pkg::OFS_RAMP, 32'h0, q);
        chk(q, 32'hc8, "resistor ramp");
        d_idx <= 5'h01;
        repeat (2 * T) @(posedge clk_i);
        wb(1'b0, sspg_pkg::OFS_DELAY, 32'h0, q);
        chk(q, 32'h46, "resistor reread");
        // Ramp of 5 ms stays well above the inrush advice
        d_lo <= 2'h1; d_hi <= 2'h0; r_pin <= 2'h1;
        restore();
        wb(1'b0, sspg_pkg::OFS_GOOD_DLY, 32'h0, q);
        chk(q, 32'h5, "good delay default");
        // Clock is long stable before enable rises
        en <= 1'b1;
        wait_for(1, 8 * T, n);
        wait_for(2, 8 * T, n);
        chk_rng(n, 3 * T, 5 * T + 4, "ramp length");
        wait_for(3, 8 * T, n);
        chk_rng(n, 5 * T - 2, 6 * T + 6, "good delay");
        wb(1'b1, sspg_pkg::OFS_CTRL, 32'h4, q);
        wait_for(4, 6, n);
        wb(1'b0, sspg_pkg::OFS_STATUS, 32'h0, q);
        chk({q[sspg_pkg::ST_GOOD_BIT], output_good_o}, 2'h2, "good low while inverted");
        wb(1'b1, sspg_pkg::OFS_CTRL, 32'h0, q);
        wait_for(3, 6, n);
        sag <= 1'b1;
        wait_for(4, 6, n);
        sag <= 1'b0;
        wait_for(3, 8 * T, n);
        trip <= 1'b1;
        wait_for(4, 6, n);
        trip <= 1'b0;
        en <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk(vref_o, 12'h000, "reference kept after disable");
        wb(1'b1, sspg_pkg::OFS_CTRL, 32'h2, q);
        wb(1'b1, sspg_pkg::OFS_RAMP, 32'h0, q);
        wb(1'b1, sspg_pkg::OFS_GOOD_DLY, 32'h3, q);
        for (int j = 0; j < 2; j++) begin
            wb(1'b1, sspg_pkg::OFS_DELAY, j ? 32'h4 : 32'h0, q);
            en <= 1'b1;
            wait_for(1, 8 * T, n);
            chk_rng(n, (j ? 4 : 2) * T, (j ? 4 : 2) * T + 6, "pre-ramp delay");
            chk(vref_o, 12'h800, "zero ramp not immediate");
            wait_for(3, 8 * T, n);
            chk_rng(n, 3 * T - 2, 4 * T + 6, "own good delay");
            en <= 1'b0;
            repeat (6) @(posedge clk_i);
        end
        nvm_v <= 1'b1;
        restore();
        wb(1'b0, sspg_pkg::OFS_DELAY, 32'h0, q);
        chk(q, 32'h07, "stored delay not loaded");
        report_and_stop();
    end
endmodule // startup_softstart_powergood_seq_tb
